// ==== verification/antenna_tune_adc_regs_test.sv ====
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  errors++; $display("unexpected %s exp %h got %h", nm, ex, gt); end end

module antenna_tune_adc_regs_test
  import atrg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // Stimulus signals
  // ----------------------------------------------------------------------
  logic       clk_sys   = 1'b0;
  logic       rstn      = 1'b0;
  logic       restore   = 1'b0;
  logic       conv_done = 1'b0;
  logic [7:0] conv_data = 8'h00;
  logic       tune_done = 1'b0;
  logic [3:0] tune_code = 4'h0;
  logic       tune_fail = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic       wr        = 1'b0;
  logic       rd        = 1'b0;
  logic [7:0] rdata;
  logic [3:0] pins_one;
  logic [3:0] pins_two;
  logic       irq;
  int         errors      = 0;
  int         checks_done = 0;

  always #50 clk_sys = ~clk_sys;

  atrg_regs dut (
    .i_clk_sys            (clk_sys),
    .i_rstn               (rstn),
    .i_restore            (restore),
    .i_conv_done          (conv_done),
    .i_conv_data          (conv_data),
    .i_tune_done          (tune_done),
    .i_tune_code          (tune_code),
    .i_tune_fail          (tune_fail),
    .i_addr               (addr),
    .i_wdata              (wdata),
    .i_wr                 (wr),
    .i_rd                 (rd),
    .o_rdata              (rdata),
    .o_tune_pin_group_one (pins_one),
    .o_tune_pin_group_two (pins_two),
    .o_irq                (irq)
  );

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  // Each strobe task starts just after a rising edge and leaves one spare cycle,
  // so a strobe is never raised and lowered in the same time step.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
    @(posedge clk_sys);
  endtask : wr_reg

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] ex);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(negedge clk_sys);
    `CHK("rdata", ex, rdata)
    @(posedge clk_sys);
  endtask : chk_rd

  task automatic chk_out(input logic [3:0] ex, input logic ex_irq);
    @(negedge clk_sys);
    `CHK("pins_one", ex, pins_one)
    `CHK("pins_two", ex, pins_two)
    `CHK("irq", ex_irq, irq)
    @(posedge clk_sys);
  endtask : chk_out

  task automatic conv(input logic [7:0] d);
    conv_data <= d;
    conv_done <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    @(posedge clk_sys);
  endtask : conv

  task automatic tune(input logic [3:0] c, input logic f);
    tune_code <= c;
    tune_fail <= f;
    tune_done <= 1'b1;
    @(posedge clk_sys);
    tune_done <= 1'b0;
    @(posedge clk_sys);
  endtask : tune

  task automatic chk_clear();
    chk_rd(ADDR_CONV, RST_CONV);
    chk_rd(ADDR_TUNE, RST_TUNE);
    chk_rd(ADDR_OVRD, RST_OVRD);
    chk_rd(ADDR_IRQ_ST, 8'h00);
    chk_rd(ADDR_IRQ_MSK, 8'h00);
    chk_out(RST_CODE, 1'b0);
  endtask : chk_clear

  task automatic conclude();
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    // Internal reset copy lags two edges
    repeat (3) @(posedge clk_sys);
    chk_clear();
    conv(8'hA5);
    conv(8'h81);
    chk_rd(ADDR_CONV, 8'h81);
    wr_reg(ADDR_CONV, 8'hFF);
    chk_rd(ADDR_CONV, 8'h81);
    tune(4'hB, 1'b0);
    chk_rd(ADDR_TUNE, 8'hB0);
    chk_out(4'hB, 1'b0);
    tune(4'h6, 1'b1);
    chk_rd(ADDR_TUNE, 8'h68);
    chk_out(4'h6, 1'b0);
    tune(4'h3, 1'b0);
    wr_reg(ADDR_TUNE, 8'hFF);
    chk_rd(ADDR_TUNE, 8'h30);
    wr_reg(ADDR_OVRD, 8'hC8);
    chk_rd(ADDR_OVRD, 8'hC8);
    chk_out(4'h9, 1'b0);
    wr_reg(ADDR_OVRD, 8'hFF);
    chk_rd(ADDR_OVRD, 8'hF8);
    chk_out(4'hF, 1'b0);
    wr_reg(ADDR_OVRD, 8'h57);
    chk_rd(ADDR_OVRD, 8'h50);
    chk_out(4'h3, 1'b0);
    // Interrupt: all three events seen above, mask still closed
    chk_rd(ADDR_IRQ_ST, 8'h07);
    chk_rd(8'h33, 8'h00);
    wr_reg(ADDR_IRQ_MSK, 8'h01);
    chk_out(4'h3, 1'b1);
    wr_reg(ADDR_IRQ_ST, 8'h01);
    chk_out(4'h3, 1'b0);
    chk_rd(ADDR_IRQ_ST, 8'h06);
    wr_reg(ADDR_IRQ_MSK, 8'h04);
    chk_out(4'h3, 1'b1);
    wr_reg(ADDR_OVRD, 8'hC8);
    restore <= 1'b1;
    @(posedge clk_sys);
    restore <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk_clear();
    conclude();
  end

  // Generous bound: the sequence needs well under 300 cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    errors++;
    conclude();
  end

endmodule : antenna_tune_adc_regs_test

// ==== verilog/atrg_pkg.sv ====
package atrg_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV    = 8'h0D;
  localparam logic [7:0] ADDR_TUNE    = 8'h0E;
  localparam logic [7:0] ADDR_OVRD    = 8'h0F;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h21;

  // ----------------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------------
  localparam int TUNE_CODE_HI = 7;
  localparam int TUNE_CODE_LO = 4;
  localparam int TUNE_ERR_BIT = 3;
  localparam int OVRD_SEL_BIT = 7;
  localparam int OVRD_CODE_HI = 6;
  localparam int OVRD_CODE_LO = 3;

  // Interrupt status bits
  localparam int IRQ_CONV_BIT = 0;
  localparam int IRQ_TUNE_BIT = 1;
  localparam int IRQ_ERR_BIT  = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_CONV = 8'h00;
  localparam logic [7:0] RST_TUNE = 8'h00;
  localparam logic [7:0] RST_OVRD = 8'h00;
  localparam logic [2:0] RST_IRQ  = 3'h0;
  localparam logic [3:0] RST_CODE = 4'h0;

endpackage : atrg_pkg

// ==== verilog/atrg_regs.sv ====
// How it works
// - Latest 8-bit conversion result readable at 0D, bit 7 is MSB.
// - Conversion result clears at power-up and on restore-defaults.
// - Tuning completion stores 4-bit result in bits 7..4 at 0E.
// - Bit 3 at 0E flags a failed tuning sequence.
// - Whole tuning result register clears at power-up and restore-defaults.
// - Override bit 7 zero makes switches follow stored tuning result.
// - Override bit 7 one drives switches from override bits 6..3.
// - Each one bit turns on its transistor on both pin groups.
// - Selector picks switch source; override register resets to zero.
module atrg_regs
  import atrg_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rstn,
  input  wire logic       i_restore,
  input  wire logic       i_conv_done,
  input  wire logic [7:0] i_conv_data,
  input  wire logic       i_tune_done,
  input  wire logic [3:0] i_tune_code,
  input  wire logic       i_tune_fail,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic      [3:0] o_tune_pin_group_one,
  output logic      [3:0] o_tune_pin_group_two,
  output logic            o_irq
);

  logic       rstn;
  logic [7:0] conv_q;
  logic [3:0] tune_code_q;
  logic       tune_err_q;
  logic       ovrd_sel_q;
  logic [3:0] ovrd_code_q;
  logic [2:0] irq_st_q;
  logic [2:0] irq_msk_q;
  logic [2:0] irq_ev;
  logic [3:0] sel_code;
  logic [7:0] rdata_d;

  atrg_sync u_sync (
    .i_clk  (i_clk_sys),
    .i_rstn (i_rstn),
    .o_rstn (rstn)
  );

  // ----------------------------------------------------------------------
  // Conversion result
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      conv_q <= RST_CONV;
    end else if (i_restore) begin
      conv_q <= RST_CONV;
    end else if (i_conv_done) begin
      conv_q <= i_conv_data;
    end
  end

  // ----------------------------------------------------------------------
  // Tuning result
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      tune_code_q <= RST_CODE;
      tune_err_q  <= 1'b0;
    end else if (i_restore) begin
      tune_code_q <= RST_CODE;
      tune_err_q  <= 1'b0;
    end else if (i_tune_done) begin
      tune_code_q <= i_tune_code;
      tune_err_q  <= i_tune_fail;
    end
  end

  // ----------------------------------------------------------------------
  // Override register
  // ----------------------------------------------------------------------
  // Low bits are not stored at all, so writes there vanish
  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      ovrd_sel_q  <= RST_OVRD[OVRD_SEL_BIT];
      ovrd_code_q <= RST_OVRD[OVRD_CODE_HI:OVRD_CODE_LO];
    end else if (i_restore) begin
      ovrd_sel_q  <= RST_OVRD[OVRD_SEL_BIT];
      ovrd_code_q <= RST_OVRD[OVRD_CODE_HI:OVRD_CODE_LO];
    end else if (i_wr && i_addr == ADDR_OVRD) begin
      ovrd_sel_q  <= i_wdata[OVRD_SEL_BIT];
      ovrd_code_q <= i_wdata[OVRD_CODE_HI:OVRD_CODE_LO];
    end
  end

  // ----------------------------------------------------------------------
  // Switch drive
  // ----------------------------------------------------------------------
  always_comb begin
    if (ovrd_sel_q) begin
      sel_code = ovrd_code_q;
    end else begin
      sel_code = tune_code_q;
    end
  end

  // Registered so the pins never glitch on a select change
  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      o_tune_pin_group_one <= RST_CODE;
      o_tune_pin_group_two <= RST_CODE;
    end else begin
      o_tune_pin_group_one <= sel_code;
      o_tune_pin_group_two <= sel_code;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  assign irq_ev = {i_tune_done & i_tune_fail, i_tune_done, i_conv_done};

  // New event beats a same-cycle write-one clear
  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_st_q <= RST_IRQ;
    end else if (i_restore) begin
      irq_st_q <= RST_IRQ;
    end else if (i_wr && i_addr == ADDR_IRQ_ST) begin
      irq_st_q <= (irq_st_q & ~i_wdata[2:0]) | irq_ev;
    end else begin
      irq_st_q <= irq_st_q | irq_ev;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_msk_q <= RST_IRQ;
    end else if (i_restore) begin
      irq_msk_q <= RST_IRQ;
    end else if (i_wr && i_addr == ADDR_IRQ_MSK) begin
      irq_msk_q <= i_wdata[2:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_st_q & irq_msk_q);
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    unique case (i_addr)
      ADDR_CONV: begin
        rdata_d = conv_q;
      end
      ADDR_TUNE: begin
        rdata_d = {tune_code_q, tune_err_q, 3'h0};
      end
      ADDR_OVRD: begin
        rdata_d = {ovrd_sel_q, ovrd_code_q, 3'h0};
      end
      ADDR_IRQ_ST: begin
        rdata_d = {5'h00, irq_st_q};
      end
      ADDR_IRQ_MSK: begin
        rdata_d = {5'h00, irq_msk_q};
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge rstn) begin
    if (!rstn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_conv_capture: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    i_conv_done && !i_restore |=> conv_q == $past(i_conv_data))
    else $error("conversion result not captured");

  // Bus writes to 0D must never reach the stored result
  a_conv_hold: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    !i_conv_done && !i_restore |=> $stable(conv_q))
    else $error("conversion result changed without an event");

  a_conv_restore: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    i_restore |=> conv_q == RST_CONV)
    else $error("conversion result not cleared");

  a_tune_capture: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    i_tune_done && !i_restore |=> tune_code_q == $past(i_tune_code))
    else $error("tuning code not stored");

  a_tune_hold: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    !i_tune_done && !i_restore
    |=> $stable(tune_code_q) && $stable(tune_err_q))
    else $error("tuning register changed without an event");

  a_tune_errflag: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    i_tune_done && i_tune_fail && !i_restore |=> tune_err_q)
    else $error("tuning error flag not set");

  // Flag follows each completion, so a good run drops an old error
  a_tune_errclear: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    i_tune_done && !i_tune_fail && !i_restore |=> !tune_err_q)
    else $error("tuning error flag not cleared");

  a_tune_restore: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    i_restore |=> tune_code_q == RST_CODE && !tune_err_q)
    else $error("tuning register not cleared");

  a_ovrd_write: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    i_wr && i_addr == ADDR_OVRD && !i_restore
    |=> {ovrd_sel_q, ovrd_code_q, 3'h0} == ($past(i_wdata) & 8'hF8))
    else $error("override write not stored");

  a_ovrd_hold: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    !(i_wr && i_addr == ADDR_OVRD) && !i_restore
    |=> $stable(ovrd_sel_q) && $stable(ovrd_code_q))
    else $error("override changed without a write");

  a_pins_auto: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    !ovrd_sel_q |=> o_tune_pin_group_one == $past(tune_code_q))
    else $error("pins do not follow tuning result");

  a_pins_manual: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    ovrd_sel_q |=> o_tune_pin_group_one == $past(ovrd_code_q))
    else $error("pins do not follow override code");

  a_pins_both: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    o_tune_pin_group_one == o_tune_pin_group_two)
    else $error("pin groups differ");

  a_ovrd_restore: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    i_restore |=> !ovrd_sel_q ##1 o_tune_pin_group_one == RST_CODE)
    else $error("override not cleared");

  a_low_bits_zero: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    i_rd && (i_addr == ADDR_TUNE || i_addr == ADDR_OVRD)
    |=> o_rdata[2:0] == 3'h0)
    else $error("unused bits read nonzero");

  a_rdata_idle: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside the read cycle");

  // ----------------------------------------------------------------------
  // Interrupt assertions
  // ----------------------------------------------------------------------
  // Set must win even when a clear lands in the same cycle
  a_irq_sticky: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    !i_restore |=> (irq_st_q & $past(irq_ev)) == $past(irq_ev))
    else $error("event did not set its status bit");

  a_irq_hold: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    !i_restore && !(i_wr && i_addr == ADDR_IRQ_ST)
    |=> (irq_st_q & $past(irq_st_q)) == $past(irq_st_q))
    else $error("status bit dropped without a clear");

  a_irq_w1c: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    i_wr && i_addr == ADDR_IRQ_ST && !i_restore && irq_ev == 3'h0
    |=> ({5'h00, irq_st_q} & $past(i_wdata)) == 8'h00)
    else $error("write of one did not clear status");

  a_irq_restore: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    i_restore |=> irq_st_q == RST_IRQ && irq_msk_q == RST_IRQ)
    else $error("interrupt registers not cleared");

  a_irq_raise: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    |(irq_st_q & irq_msk_q) |=> o_irq)
    else $error("interrupt not raised");

  a_irq_drop: assert property (
    @(posedge i_clk_sys) disable iff (!rstn)
    !(|(irq_st_q & irq_msk_q)) |=> !o_irq)
    else $error("interrupt not dropped");

  c_tune_fail: cover property (@(posedge i_clk_sys) disable iff (!rstn)
    i_tune_done && i_tune_fail);
  c_manual_mode: cover property (@(posedge i_clk_sys) disable iff (!rstn)
    $rose(ovrd_sel_q));
  c_irq_raise: cover property (@(posedge i_clk_sys) disable iff (!rstn)
    $rose(o_irq));
  c_restore_run: cover property (@(posedge i_clk_sys) disable iff (!rstn)
    i_restore && ovrd_sel_q);
  c_ovrd_write: cover property (@(posedge i_clk_sys) disable iff (!rstn)
    i_wr && i_addr == ADDR_OVRD);

endmodule : atrg_regs

// ==== verilog/atrg_sync.sv ====
module atrg_sync (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  output logic      o_rstn
);
  logic       meta_q;
  logic       sync_q;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  // Asserts at once, releases two edges late
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      sync_q <= meta_q;
    end
  end

  assign o_rstn = sync_q;

endmodule : atrg_sync
